// ===== bench/cmo_mem_model.sv
// behavioural model of cache levels, write-combining buffers and external caches
`timescale 1ns/1ps
module cmo_mem_model (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic slow,
	input  wire logic hit,
	input  wire logic dirty,
	input  wire logic lookup_req,
	input  wire logic wc_drain_req,
	input  wire logic wback_req,
	input  wire logic inval_req,
	input  wire logic ext_req,
	output logic      lookup_done,
	output logic      lookup_hit,
	output logic      lookup_dirty,
	output logic      wc_drain_done,
	output logic      wback_done,
	output logic      inval_done,
	output logic      ext_ack
);
	logic       pend;
	logic [4:0] rq;
	logic [4:0] dn;
	logic [2:0] cnt [5];
	assign rq = {ext_req, inval_req, wback_req, wc_drain_req, pend};
	assign {ext_ack, inval_done, wback_done, wc_drain_done, lookup_done} = dn;
	// status lines carry junk outside the done pulse
	assign lookup_hit   = dn[0] ? hit : ~hit;
	assign lookup_dirty = dn[0] ? dirty : ~dirty;
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		pend <= rst_n && (lookup_req || (pend && !dn[0]));
		for (int i = 0; i < 5; i++) begin
			if (!rst_n || !rq[i] || dn[i]) begin
				cnt[i] <= 3'h0;
				dn[i]  <= 1'b0;
			end else if (cnt[i] == (slow ? 3'h5 : 3'h0)) begin
				dn[i] <= 1'b1;
			end else begin
				cnt[i] <= cnt[i] + 3'h1;
			end
		end
	end
endmodule

// ===== bench/cmo_unit_chk.sv
// port assertions for the maintenance sequencer
`timescale 1ns/1ps
module cmo_unit_chk
	import cmo_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       op_valid,
	input wire logic [3:0] op_code,
	input wire logic [2:0] op_mem_type,
	input wire logic       op_ready,
	input wire logic       retire,
	input wire logic       hold_fetch,
	input wire logic       hold_loads,
	input wire logic       hold_stores,
	input wire logic       loads_idle,
	input wire logic       stores_idle,
	input wire logic       wbuf_empty,
	input wire logic       pref_req,
	input wire logic       pref_modified,
	input wire logic       lookup_req,
	input wire logic       wc_drain_req,
	input wire logic       wback_req,
	input wire logic       wback_done,
	input wire logic       inval_req,
	input wire logic       ext_req,
	input wire logic [1:0] ext_kind
);
	logic       busy;
	logic       uc;
	logic       wbd;
	logic       wcs;
	logic [3:0] cur;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		busy <= rst_n && ((op_valid && op_ready) || (busy && !retire));
		wbd  <= rst_n && !(op_valid && op_ready) && (wbd || wback_done);
		wcs  <= rst_n && !(op_valid && op_ready) && (wcs || wc_drain_req);
		if (op_valid && op_ready) begin
			cur <= op_code;
			uc  <= op_mem_type < 3'h2;
		end
	end
	pref_pair_a: assert property (pref_modified |-> pref_req && cur == CMO_OP_PREF_WRITE)
		else $error("modified preload without write hint");
	st_fence_a: assert property (retire && cur == CMO_OP_STORE_FENCE_OP |-> $past(stores_idle))
		else $error("store fence retired with stores pending");
	st_hold_a: assert property (busy && !retire && cur inside {CMO_OP_STORE_FENCE_OP,
		CMO_OP_FULL_FENCE, CMO_OP_SERIALIZE} |-> hold_stores) else $error("stores not held");
	ld_fence_a: assert property (retire && cur == CMO_OP_LOAD_FENCE_OP |-> $past(loads_idle))
		else $error("load fence retired with loads pending");
	ld_hold_a: assert property (busy && !retire && cur inside {CMO_OP_LOAD_FENCE_OP,
		CMO_OP_FULL_FENCE, CMO_OP_SERIALIZE} |-> hold_loads) else $error("loads not held");
	full_fence_a: assert property (retire
		&& cur inside {CMO_OP_FULL_FENCE, CMO_OP_SERIALIZE}
		|-> $past(loads_idle && stores_idle && wbuf_empty)) else $error("serializer retired early");
	uc_skip_a: assert property (busy && uc && cur == CMO_OP_LINE_FLUSH |-> !lookup_req)
		else $error("lookup on uncacheable flush");
	wc_drain_a: assert property (retire && cur == CMO_OP_LINE_FLUSH |-> wcs)
		else $error("flush retired without buffer drain");
	wb_first_a: assert property (inval_req && cur == CMO_OP_WB_INV_ALL |-> wbd)
		else $error("invalidate before writeback finished");
	inv_no_wb_a: assert property (busy && cur == CMO_OP_INV_ALL |-> !wback_req)
		else $error("writeback during discard");
	ext_kind_a: assert property (ext_req
		|-> ext_kind == (cur == CMO_OP_WB_INV_ALL ? 2'h1 : 2'h2))
		else $error("wrong external cycle kind");
	done_gate_a: assert property (retire
		|-> !(wback_req || inval_req || ext_req || wc_drain_req))
		else $error("retire with work pending");
	fetch_hold_a: assert property (busy && !retire
		&& cur inside {CMO_OP_FULL_FENCE, CMO_OP_WB_INV_ALL, CMO_OP_INV_ALL, CMO_OP_SERIALIZE,
		CMO_OP_IDENT} |-> hold_fetch) else $error("fetch not held");
	ret_pulse_a: assert property (retire |-> !op_ready ##1 !retire ##[0:1] op_ready)
		else $error("retire pulse or ready return wrong");
	cover property (retire && cur == CMO_OP_LINE_FLUSH && wbd);
	cover property (retire && cur == CMO_OP_WB_INV_ALL);
	cover property (pref_modified);
endmodule
bind cmo_unit cmo_unit_chk u_chk (.clk_sys, .rst_n, .op_valid, .op_code, .op_mem_type, .op_ready,
	.retire, .hold_fetch, .hold_loads, .hold_stores, .loads_idle, .stores_idle, .wbuf_empty,
	.pref_req, .pref_modified, .lookup_req, .wc_drain_req, .wback_req, .wback_done, .inval_req,
	.ext_req, .ext_kind);

// ===== bench/cmo_unit_tb_top.sv
// self-checking bench for the maintenance sequencer
`timescale 1ns/1ps
`include "cmo_consts.svh"
module cmo_unit_tb_top
	import cmo_pkg::*;
;
	localparam int LEVELS = 3;
	logic clk_sys, rst_n, op_valid, slow, hit, dirty, early, cc, clr;
	logic loads_idle, stores_idle, wbuf_empty, op_ready, retire, hold_fetch, hold_loads;
	logic hold_stores, pref_req, pref_modified, lookup_req, lookup_done, lookup_hit, lookup_dirty;
	logic wc_drain_req, wc_drain_done, wback_req, wback_all, wback_done, inval_req, inval_all;
	logic inval_done, ext_req, ext_ack;
	logic [1:0]  ext_kind;
	logic [2:0]  op_mem_type, ty;
	logic [3:0]  op_code;
	logic [7:0]  seen;
	logic [31:0] op_leaf, op_subleaf, sb;
	logic [31:0] first_result_register, second_result_register, third_result_register;
	logic [47:0] op_addr, cache_addr;
	int          failures, n_tests;
	cmo_unit dut (.clk_sys, .rst_n, .op_valid, .op_code, .op_addr, .op_mem_type, .op_leaf,
		.op_subleaf, .op_ready, .retire, .first_result_register, .second_result_register,
		.third_result_register, .hold_fetch, .hold_loads, .hold_stores, .loads_idle,
		.stores_idle, .wbuf_empty, .pref_req, .pref_modified, .cache_addr, .lookup_req,
		.lookup_done, .lookup_hit, .lookup_dirty, .wc_drain_req, .wc_drain_done, .wback_req,
		.wback_all, .wback_done, .inval_req, .inval_all, .inval_done, .ext_req, .ext_kind, .ext_ack);
	cmo_mem_model u_mem (.clk_sys, .rst_n, .slow, .hit, .dirty, .lookup_req, .wc_drain_req,
		.wback_req, .inval_req, .ext_req, .lookup_done, .lookup_hit, .lookup_dirty,
		.wc_drain_done, .wback_done, .inval_done, .ext_ack);
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) seen <= clr ? 8'h00 : seen | {pref_modified, pref_req, lookup_req,
		wback_req, wback_all & wback_req, inval_req, inval_all & inval_req, ext_req};
	// level number above the type, type 1 for the first level and 3 for the rest
	function automatic logic [31:0] ctype(input logic [31:0] s);
		if (s >= LEVELS) return 32'h00000000;
		return {24'h000000, 3'(s + 1), s == 0 ? 5'h01 : 5'h03};
	endfunction
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t got %0h exp %0h", $time, g, e);
		end
	endtask
	task end_sim;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// idle lines in mask m stay low for a random spell after accept
	task automatic run(input logic [3:0] c, input logic [2:0] t, input logic [2:0] m,
		input logic [31:0] lf, input logic [31:0] s);
		int k;
		@(negedge clk_sys);
		for (k = 0; k < 20 && op_ready !== 1'b1; k++) @(negedge clk_sys);
		chk(op_ready, 1'b1);
		{loads_idle, stores_idle, wbuf_empty} = ~m;
		clr = 1'b1;
		slow = 1'($urandom);
		op_code = c;
		op_mem_type = t;
		op_leaf = lf;
		op_subleaf = s;
		op_addr = 48'({$urandom, $urandom});
		op_valid = 1'b1;
		@(negedge clk_sys);
		op_valid = 1'b0;
		clr = 1'b0;
		early = 1'b0;
		repeat ($urandom % 4 + 2) begin
			@(negedge clk_sys);
			early |= retire;
		end
		{loads_idle, stores_idle, wbuf_empty} = 3'h7;
		if (m != 3'h0) chk(early, 1'b0);
		if (!early) begin
			for (k = 0; k < 100 && retire !== 1'b1; k++) @(negedge clk_sys);
			chk(retire, 1'b1);
		end
		$display("op %0h done", c);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		failures++;
		end_sim;
	end
	initial begin
		{rst_n, op_valid, clr, op_code, op_addr, op_mem_type, op_leaf, op_subleaf} = '0;
		{loads_idle, stores_idle, wbuf_empty, slow, hit, dirty} = 6'h38;
		failures = 0;
		n_tests = 0;
		void'($urandom(32'h99E3));
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys) rst_n = 1'b1;
		for (int i = 1; i < 3; i++) begin
			run(4'(i), 3'h6, 3'h0, 32'h0, 32'h0);
			chk(seen[7:6], {i == 2, 1'b1});
		end
		run(CMO_OP_STORE_FENCE_OP, 3'h6, 3'h2, 32'h0, 32'h0);
		run(CMO_OP_LOAD_FENCE_OP, 3'h6, 3'h4, 32'h0, 32'h0);
		for (int i = 0; i < 3; i++) begin
			run(CMO_OP_FULL_FENCE, 3'h6, 3'(1 << i), 32'h0, 32'h0);
			run(CMO_OP_SERIALIZE, 3'h6, 3'(1 << i), 32'h0, 32'h0);
		end
		for (int i = 0; i < 6; i++) begin
			ty = i > 3 ? 3'(i - 4) : 3'h6;
			{hit, dirty} = 2'(i);
			run(CMO_OP_LINE_FLUSH, ty, 3'($urandom % 8), 32'h0, 32'h0);
			cc = ty > 3'h1;
			chk(cache_addr, op_addr);
			chk(seen[5], cc);
			chk(seen[4], cc & hit & dirty);
			chk(seen[2:0], {cc & hit, 1'b0, cc});
		end
		run(CMO_OP_WB_INV_ALL, 3'h6, 3'($urandom % 7 + 1), 32'h0, 32'h0);
		chk(seen[4:0], 5'h1F);
		run(CMO_OP_INV_ALL, 3'h6, 3'($urandom % 7 + 1), 32'h0, 32'h0);
		chk(seen[4:0], 5'h07);
		// walk downwards so the topology query below overwrites a nonzero result
		for (int s = 4; s >= 0; s--) begin
			sb = s < 4 ? 32'(s) : LEVELS + $urandom % 100;
			run(CMO_OP_IDENT, 3'h6, 3'h0, `CMO_LEAF_CACHE, sb);
			chk(first_result_register, ctype(sb));
		end
		run(CMO_OP_IDENT, 3'h6, 3'h0, `CMO_LEAF_TOPO, 32'h0);
		chk(first_result_register, 32'h0);
		chk(second_result_register, 32'h100);
		chk(third_result_register, 32'h0);
		end_sim;
	end
endmodule

// ===== verilog/cmo_consts.svh
// constants for the cache maintenance ordering unit
`ifndef CMO_CONSTS_SVH
`define CMO_CONSTS_SVH
`define CMO_OP_W          4
`define CMO_LEAF_CACHE    32'h8000001D
`define CMO_LEAF_TOPO     32'h8000001E
`define CMO_TYPE_UC       3'h0
`define CMO_TYPE_WC       3'h1
`define CMO_CTYPE_LSB     0
`define CMO_CTYPE_W       5
`define CMO_LINE_LSB      6
`endif

// ===== verilog/cmo_ident.sv
// identification table for cache and processor topology leaves
`timescale 1ns/1ps
`include "cmo_consts.svh"
module cmo_ident
	import cmo_pkg::*;
#(
	parameter int          LEVELS  = 3,
	parameter logic [31:0] CTRL_ID = 32'h00000000,
	parameter logic [31:0] UNIT_ID = 32'h00000100,
	parameter logic [31:0] NODE_ID = 32'h00000000
) (
	cmo_ident_if.tbl q
);
	always_comb begin
		q.res_a = 32'h00000000;
		q.res_b = 32'h00000000;
		q.res_c = 32'h00000000;
		if (q.leaf == `CMO_LEAF_CACHE) begin
			if (q.subleaf < 32'(LEVELS)) begin
				q.res_a[`CMO_CTYPE_LSB +: `CMO_CTYPE_W] = (q.subleaf == 32'h0) ? 5'h1 : 5'h3;
				q.res_a[7:5] = 3'(q.subleaf + 32'h1);
			end
		end else if (q.leaf == `CMO_LEAF_TOPO) begin
			q.res_a = CTRL_ID;
			q.res_b = UNIT_ID;
			q.res_c = NODE_ID;
		end
	end
endmodule

// ===== verilog/cmo_ident_if.sv
// query carrier between sequencer and identification table
`timescale 1ns/1ps
interface cmo_ident_if;
	logic [31:0] leaf;
	logic [31:0] subleaf;
	logic [31:0] res_a;
	logic [31:0] res_b;
	logic [31:0] res_c;
	modport seq (output leaf, output subleaf, input res_a, input res_b, input res_c);
	modport tbl (input leaf, input subleaf, output res_a, output res_b, output res_c);
endinterface

// ===== verilog/cmo_pkg.sv
// types shared by the maintenance unit files
package cmo_pkg;
	typedef enum logic [3:0] {
		CMO_OP_NONE       = 4'h0,
		CMO_OP_PREF_READ  = 4'h1,
		CMO_OP_PREF_WRITE = 4'h2,
		CMO_OP_STORE_FENCE_OP  = 4'h3,
		CMO_OP_LOAD_FENCE_OP  = 4'h4,
		CMO_OP_FULL_FENCE = 4'h5,
		CMO_OP_LINE_FLUSH = 4'h6,
		CMO_OP_WB_INV_ALL = 4'h7,
		CMO_OP_INV_ALL    = 4'h8,
		CMO_OP_SERIALIZE  = 4'h9,
		CMO_OP_IDENT      = 4'hA
	} cmo_op_t;
	typedef enum logic [6:0] {
		CMO_ST_IDLE  = 7'b0000001,
		CMO_ST_DRAIN = 7'b0000010,
		CMO_ST_LOOK  = 7'b0000100,
		CMO_ST_WBACK = 7'b0001000,
		CMO_ST_INVAL = 7'b0010000,
		CMO_ST_EXT   = 7'b0100000,
		CMO_ST_DONE  = 7'b1000000
	} cmo_state_t;
endpackage

// ===== verilog/cmo_unit.sv
// cache maintenance and ordering sequencer
// Notes on behaviour
// - write-intent preload may install the line modified; hints never change results
// - store fence: older stores reach memory before younger stores show
// - load fence: older loads complete before younger loads read memory
// - full fence: all older loads and stores complete before younger ones
// - line flush looks up the address and invalidates the whole hit line
// - modified or owned line is written back before invalidation
// - line flush reaches all levels, done only when invalid everywhere; UC/WC type retires with no invalidate or external cycle
// - uncacheable or write-combining type skips the cache lookup sweep
// - write-combining buffer covering the address is drained during flush
// - whole writeback: write back all dirty lines, then invalidate all
// - whole writeback sends external writeback-invalidate bus cycle
// - invalidate-only marks all lines invalid without writeback
// - invalidate-only sends external invalidate bus cycle
// - serializing op retires with all earlier ones before next fetch
// - retired means executed, registers updated, memory done, buffers drained
// - listed instruction classes are treated as serializing
// - cache leaf gives one level per subleaf, zero type ends the list
// - topology leaf gives controller id, unit and node identifiers
`timescale 1ns/1ps
`include "cmo_consts.svh"
module cmo_unit
	import cmo_pkg::*;
#(
	parameter int ADDR_W = 48
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              op_valid,
	input  wire logic [3:0]        op_code,
	input  wire logic [ADDR_W-1:0] op_addr,
	input  wire logic [2:0]        op_mem_type,
	input  wire logic [31:0]       op_leaf,
	input  wire logic [31:0]       op_subleaf,
	output logic                   op_ready,
	output logic                   retire,
	output logic [31:0]            first_result_register,
	output logic [31:0]            second_result_register,
	output logic [31:0]            third_result_register,
	output logic                   hold_fetch,
	output logic                   hold_loads,
	output logic                   hold_stores,
	input  wire logic              loads_idle,
	input  wire logic              stores_idle,
	input  wire logic              wbuf_empty,
	output logic                   pref_req,
	output logic                   pref_modified,
	output logic [ADDR_W-1:0]      cache_addr,
	output logic                   lookup_req,
	input  wire logic              lookup_done,
	input  wire logic              lookup_hit,
	input  wire logic              lookup_dirty,
	output logic                   wc_drain_req,
	input  wire logic              wc_drain_done,
	output logic                   wback_req,
	output logic                   wback_all,
	input  wire logic              wback_done,
	output logic                   inval_req,
	output logic                   inval_all,
	input  wire logic              inval_done,
	output logic                   ext_req,
	output logic [1:0]             ext_kind,
	input  wire logic              ext_ack
);
	cmo_state_t        state, next_state;
	cmo_op_t           op, next_op;
	logic [ADDR_W-1:0] next_cache_addr;
	logic              next_op_ready, next_retire, next_hold_fetch;
	logic              next_hold_loads, next_hold_stores, next_pref_req, next_pref_modified;
	logic              next_lookup_req, next_wc_drain_req, next_wback_req, next_wback_all;
	logic              next_inval_req, next_inval_all, next_ext_req;
	logic [1:0]        next_ext_kind;
	logic [31:0]       next_ra, next_rb, next_rc;
	logic              wc_pend, next_wc_pend;
	logic              quiet;
	cmo_ident_if       iq ();

	assign iq.leaf    = op_leaf;
	assign iq.subleaf = op_subleaf;
	cmo_ident u_ident (
		.q (iq.tbl)
	);

	// external bus-cycle kinds
	localparam logic [1:0] EXT_WBINV = 2'h1;
	localparam logic [1:0] EXT_INV   = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// drain condition shared by fences and serialization
	always_comb begin
		case (op)
			CMO_OP_STORE_FENCE_OP:  quiet = stores_idle;
			CMO_OP_LOAD_FENCE_OP:  quiet = loads_idle;
			CMO_OP_FULL_FENCE: quiet = loads_idle & stores_idle & wbuf_empty;
			default:           quiet = loads_idle & stores_idle & wbuf_empty;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state         = state;
		next_op            = op;
		next_cache_addr    = cache_addr;
		next_op_ready      = 1'b0;
		next_retire        = 1'b0;
		next_hold_fetch    = hold_fetch;
		next_hold_loads    = hold_loads;
		next_hold_stores   = hold_stores;
		next_pref_req      = 1'b0;
		next_pref_modified = 1'b0;
		next_lookup_req    = 1'b0;
		next_wc_drain_req  = wc_drain_req;
		next_wc_pend       = wc_pend;
		next_wback_req     = wback_req;
		next_wback_all     = wback_all;
		next_inval_req     = inval_req;
		next_inval_all     = inval_all;
		next_ext_req       = ext_req;
		next_ext_kind      = ext_kind;
		next_ra            = first_result_register;
		next_rb            = second_result_register;
		next_rc            = third_result_register;
		case (state)
			CMO_ST_IDLE: begin
				next_op_ready = 1'b1;
				if (op_valid && op_ready) begin
					next_op_ready   = 1'b0;
					next_op         = cmo_op_t'(op_code);
					next_cache_addr = op_addr;
					next_state      = CMO_ST_DRAIN;
					case (cmo_op_t'(op_code))
						CMO_OP_PREF_READ, CMO_OP_PREF_WRITE: begin
							// hints only start a preload; no result depends on them
							next_pref_req      = 1'b1;
							next_pref_modified = (cmo_op_t'(op_code) == CMO_OP_PREF_WRITE);
							next_state         = CMO_ST_DONE;
						end
						CMO_OP_STORE_FENCE_OP:  next_hold_stores = 1'b1;
						CMO_OP_LOAD_FENCE_OP:  next_hold_loads = 1'b1;
						CMO_OP_LINE_FLUSH: begin
							next_hold_fetch = 1'b1;
						end
						CMO_OP_IDENT: begin
							next_ra = iq.res_a;
							next_rb = iq.res_b;
							next_rc = iq.res_c;
							next_hold_fetch  = 1'b1;
							next_hold_loads  = 1'b1;
							next_hold_stores = 1'b1;
						end
						default: begin
							// full fence, whole-cache ops and other serializers
							next_hold_fetch  = 1'b1;
							next_hold_loads  = 1'b1;
							next_hold_stores = 1'b1;
						end
					endcase
				end
			end
			CMO_ST_DRAIN: begin
				// nothing below starts until older traffic has settled
				if (quiet) begin
					case (op)
						CMO_OP_LINE_FLUSH: begin
							next_wc_drain_req = 1'b1;
							next_wc_pend      = 1'b1;
							if (op_mem_type == `CMO_TYPE_UC || op_mem_type == `CMO_TYPE_WC)
								next_state = CMO_ST_DONE;
							else begin
								next_lookup_req = 1'b1;
								next_state      = CMO_ST_LOOK;
							end
						end
						CMO_OP_WB_INV_ALL: begin
							next_wback_req = 1'b1;
							next_wback_all = 1'b1;
							next_state     = CMO_ST_WBACK;
						end
						CMO_OP_INV_ALL: begin
							next_inval_req = 1'b1;
							next_inval_all = 1'b1;
							next_state     = CMO_ST_INVAL;
						end
						default: next_state = CMO_ST_DONE;
					endcase
				end
			end
			CMO_ST_LOOK: begin
				if (lookup_done) begin
					if (lookup_hit && lookup_dirty) begin
						next_wback_req = 1'b1;
						next_state     = CMO_ST_WBACK;
					end else if (lookup_hit) begin
						next_inval_req = 1'b1;
						next_state     = CMO_ST_INVAL;
					end else begin
						// a miss here still has to be probed outward
						next_ext_req  = 1'b1;
						next_ext_kind = EXT_INV;
						next_state    = CMO_ST_EXT;
					end
				end
			end
			CMO_ST_WBACK: begin
				if (wback_done) begin
					next_wback_req = 1'b0;
					next_inval_req = 1'b1;
					// a whole-cache writeback carries its all-lines scope into the invalidate
					next_inval_all = wback_all;
					next_state     = CMO_ST_INVAL;
				end
			end
			CMO_ST_INVAL: begin
				if (inval_done) begin
					next_inval_req = 1'b0;
					next_ext_req   = 1'b1;
					next_ext_kind  = (op == CMO_OP_WB_INV_ALL) ? EXT_WBINV : EXT_INV;
					next_state     = CMO_ST_EXT;
				end
			end
			CMO_ST_EXT: begin
				// outer caches must confirm before the op may retire
				if (ext_ack) begin
					next_ext_req  = 1'b0;
					next_ext_kind = 2'h0;
					next_state    = CMO_ST_DONE;
				end
			end
			CMO_ST_DONE: begin
				if (wc_drain_done)
					next_wc_drain_req = 1'b0;
				// retirement waits for the write-combining drain too
				if (!wc_pend || wc_drain_done) begin
					next_wc_pend     = 1'b0;
					next_wc_drain_req = 1'b0;
					next_wback_all   = 1'b0;
					next_inval_all   = 1'b0;
					next_retire      = 1'b1;
					next_hold_fetch  = 1'b0;
					next_hold_loads  = 1'b0;
					next_hold_stores = 1'b0;
					next_op          = CMO_OP_NONE;
					next_state       = CMO_ST_IDLE;
				end
			end
			default: next_state = CMO_ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state                  <= CMO_ST_IDLE;
			op                     <= CMO_OP_NONE;
			cache_addr             <= '0;
			op_ready               <= 1'b0;
			retire                 <= 1'b0;
			hold_fetch             <= 1'b0;
			hold_loads             <= 1'b0;
			hold_stores            <= 1'b0;
			pref_req               <= 1'b0;
			pref_modified          <= 1'b0;
			lookup_req             <= 1'b0;
			wc_drain_req           <= 1'b0;
			wc_pend                <= 1'b0;
			wback_req              <= 1'b0;
			wback_all              <= 1'b0;
			inval_req              <= 1'b0;
			inval_all              <= 1'b0;
			ext_req                <= 1'b0;
			ext_kind               <= 2'h0;
			first_result_register  <= 32'h00000000;
			second_result_register <= 32'h00000000;
			third_result_register  <= 32'h00000000;
		end else begin
			state                  <= next_state;
			op                     <= next_op;
			cache_addr             <= next_cache_addr;
			op_ready               <= next_op_ready;
			retire                 <= next_retire;
			hold_fetch             <= next_hold_fetch;
			hold_loads             <= next_hold_loads;
			hold_stores            <= next_hold_stores;
			pref_req               <= next_pref_req;
			pref_modified          <= next_pref_modified;
			lookup_req             <= next_lookup_req;
			wc_drain_req           <= next_wc_drain_req;
			wc_pend                <= next_wc_pend;
			wback_req              <= next_wback_req;
			wback_all              <= next_wback_all;
			inval_req              <= next_inval_req;
			inval_all              <= next_inval_all;
			ext_req                <= next_ext_req;
			ext_kind               <= next_ext_kind;
			first_result_register  <= next_ra;
			second_result_register <= next_rb;
			third_result_register  <= next_rc;
		end
	end
endmodule
